/* File: lpmc_defs.svh */
// Purpose: named constants for the low-power mode controller
// Assumes: included by its bare name from the modules and the bench
// Notes:   definitions only
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH

`define LPMC_PORT_W        8
`define LPMC_SEL_W         2
`define LPMC_NSER          3
`define LPMC_SEL_SLEEP     2'h0
`define LPMC_SEL_SUBSLEEP  2'h1
`define LPMC_SEL_SUBACT    2'h2
`define LPMC_PERS_LEGACY   1'b0
`define LPMC_PERS_NEWER    1'b1
`define LPMC_PORT_RST      8'h00
`define LPMC_OSC_ON        1'b1
`define LPMC_OSC_OFF       1'b0
`define LPMC_SER_ALL       3'h7
`define LPMC_SER_NONE      3'h0

`endif

/* File: lpmc_pkg.sv */
// Purpose: shared types of the low-power mode controller
// Assumes: lpmc_defs.svh holds the numeric constants
// Notes:   the mode enum is also a port type of the top module
package lpmc_pkg;
   // one state set covers both personalities; each uses its own subset
   typedef enum logic [2:0] {
      LPMC_ST_ACTIVE,
      LPMC_ST_SUBACTIVE,
      LPMC_ST_SLEEP,
      LPMC_ST_SUBSLEEP,
      LPMC_ST_NORM_SUB,
      LPMC_ST_HALT
   } lpmc_state_t;
endpackage

/* File: lpmc_port_hold.sv */
// Purpose: I/O port output hold register
// Assumes: hold is a registered level from the mode controller
// Notes:   while hold is high the pins keep the value from before the low-power mode
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_defs.svh"
module lpmc_port_hold (
   input  wire logic                    clk_sys,   // system clock
   input  wire logic                    reset,     // sync reset, high
   input  wire logic                    hold,      // freeze outputs
   input  wire logic [`LPMC_PORT_W-1:0] port_drv,  // live port data
   output logic      [`LPMC_PORT_W-1:0] port_out   // registered pin data
);
   // track live data only while not holding
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         port_out <= `LPMC_PORT_RST;
      end else if (!hold) begin
         port_out <= port_drv;
      end
   end
endmodule
`default_nettype wire

/* File: lpmc_ctrl.sv */
// Purpose: low-power mode controller, legacy or newer personality
// Assumes: instruction strobes are one-cycle pulses from the CPU core
// Notes:   standby/stop mode is not covered
// Functional notes
// RL1: legacy: direct sleep instruction or qualified interrupt enters subactive
// RL2: newer: CPU writes subclock select 1; CPU then runs on subsystem clock
// RL3: newer subclock normal mode: main oscillator follows software choice
// RL4: newer on subclock: converter, I2C and CRC disabled, others operable
// RL5: legacy sub modes: RTC runs if time-base, timer/serial/converter reset
// RL6: newer halt instruction stops CPU, registers kept, interrupts live
// RL7: halt keeps oscillators as before and freezes port outputs
// RL8: halt keeps RAM; RAM accessible while the transfer controller runs
// RL9: legacy sleep: CPU halted, oscillators run, peripherals run, ports kept
// RL10: legacy subsleep: CPU halted, main oscillator off, subclock on
// RL11: interrupt in halt resumes CPU at once, no stabilisation wait
// RL12: legacy sleep target comes from mode-select settings latched beforehand
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_defs.svh"
module lpmc_ctrl #(
   parameter logic PERSONALITY = `LPMC_PERS_NEWER        // legacy or newer
) (
   input  wire logic                    clk_sys,         // 250 MHz clock
   input  wire logic                    reset,           // sync reset, high
   input  wire logic                    sleep_instr,     // legacy sleep instr pulse
   input  wire logic                    halt_instr,      // newer halt instr pulse
   input  wire logic                    irq,             // interrupt request level
   input  wire logic                    mode_sel_wr,     // mode-select write pulse
   input  wire logic [`LPMC_SEL_W-1:0]  mode_sel_val,    // sleep target select
   input  wire logic                    low_speed_on,    // irq wakes to subactive
   input  wire logic                    ckc_wr,          // clock_control_reg write
   input  wire logic                    subclock_select_bit, // write data of select bit
   input  wire logic                    sub_osc_ready,   // subsystem clock running
   input  wire logic                    main_osc_req,    // software main osc choice
   input  wire logic                    sub_osc_req,     // software sub osc choice
   input  wire logic                    rtc_timebase_sel,// rtc time-base selected
   input  wire logic                    dtc_busy,        // data_transfer_controller active
   input  wire logic [`LPMC_PORT_W-1:0] port_drv,        // live port data
   output lpmc_pkg::lpmc_state_t        mode_r,          // current mode
   output logic                         cpu_run_r,       // cpu executes
   output logic                         cpu_clk_sub_r,   // cpu on subclock
   output logic                         main_osc_en_r,   // main oscillator on
   output logic                         sub_osc_en_r,    // subclock oscillator on
   output logic                         adc_en_r,        // converter enable
   output logic                         i2c_en_r,        // i2c_serial_unit enable
   output logic                         crc_en_r,        // high-speed crc enable
   output logic                         timer_rst_r,     // timer unit reset
   output logic [`LPMC_NSER-1:0]        serial_rst_r,    // legacy_serial_unit resets
   output logic                         adc_rst_r,       // converter reset
   output logic                         rtc_run_r,       // rtc clocked
   output logic                         ram_acc_en_r,    // ram access allowed
   output logic                         port_hold_r,     // ports frozen
   output logic [`LPMC_PORT_W-1:0]      port_out         // pin output data
);
   import lpmc_pkg::*;

   lpmc_state_t             state_nxt;
   logic [`LPMC_SEL_W-1:0]  sel_r;
   logic                    lson_r;
   logic                    halt_sub_r;
   logic                    legacy;
   logic                    on_sub_nxt;
   logic                    main_osc_nxt;

   assign legacy = (PERSONALITY == `LPMC_PERS_LEGACY);

   // mode settings are captured ahead of the instruction that uses them
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sel_r  <= `LPMC_SEL_SLEEP;
         lson_r <= 1'b0;
      end else if (mode_sel_wr) begin
         sel_r  <= mode_sel_val;   // RL12
         lson_r <= low_speed_on;
      end
   end

   // next mode; legacy only: an interrupt beats a sleep instruction in subactive, or in active when lson_r is set
   always_comb begin
      state_nxt = mode_r;
      if (legacy) begin
         unique case (mode_r)
            LPMC_ST_ACTIVE: begin
               if (irq && lson_r) begin
                  state_nxt = LPMC_ST_SUBACTIVE;                  // RL1
               end else if (sleep_instr) begin
                  if (sel_r == `LPMC_SEL_SUBSLEEP) begin
                     state_nxt = LPMC_ST_SUBSLEEP;                // RL10
                  end else if (sel_r == `LPMC_SEL_SUBACT) begin
                     state_nxt = LPMC_ST_SUBACTIVE;               // RL1
                  end else begin
                     state_nxt = LPMC_ST_SLEEP;                   // RL9
                  end
               end
            end
            LPMC_ST_SUBACTIVE: begin
               if (sleep_instr && !irq) begin
                  state_nxt = (sel_r == `LPMC_SEL_SUBSLEEP) ? LPMC_ST_SUBSLEEP : LPMC_ST_ACTIVE;
               end
            end
            LPMC_ST_SLEEP, LPMC_ST_SUBSLEEP: begin
               if (irq) begin
                  state_nxt = lson_r ? LPMC_ST_SUBACTIVE : LPMC_ST_ACTIVE; // RL1
               end
            end
            default: state_nxt = LPMC_ST_ACTIVE;   // newer-only codes are illegal here
         endcase
      end else begin
         unique case (mode_r)
            LPMC_ST_ACTIVE, LPMC_ST_NORM_SUB: begin
               if (halt_instr) begin
                  state_nxt = LPMC_ST_HALT;                       // RL6
               end else if (ckc_wr && subclock_select_bit && sub_osc_ready) begin
                  state_nxt = LPMC_ST_NORM_SUB;                   // RL2
               end else if (ckc_wr && !subclock_select_bit) begin
                  state_nxt = LPMC_ST_ACTIVE;
               end
            end
            LPMC_ST_HALT: begin
               if (irq) begin
                  state_nxt = halt_sub_r ? LPMC_ST_NORM_SUB : LPMC_ST_ACTIVE; // RL11
               end
            end
            default: state_nxt = LPMC_ST_ACTIVE;   // legacy-only codes are illegal here
         endcase
      end
   end

   // clock in use and main oscillator for the coming mode
   always_comb begin
      on_sub_nxt   = (state_nxt == LPMC_ST_SUBACTIVE) || (state_nxt == LPMC_ST_SUBSLEEP) ||
                     (state_nxt == LPMC_ST_NORM_SUB) || ((state_nxt == LPMC_ST_HALT) && halt_sub_r);
      main_osc_nxt = `LPMC_OSC_ON;
      if (state_nxt == LPMC_ST_NORM_SUB) begin
         main_osc_nxt = main_osc_req;                              // RL3
      end else if (state_nxt == LPMC_ST_HALT) begin
         main_osc_nxt = main_osc_en_r;                             // RL7
      end else if (legacy && on_sub_nxt) begin
         main_osc_nxt = `LPMC_OSC_OFF;                             // RL10
      end
   end

   // mode register and the clock that halt must return to
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mode_r     <= LPMC_ST_ACTIVE;
         halt_sub_r <= 1'b0;
      end else begin
         mode_r <= state_nxt;
         if (state_nxt == LPMC_ST_HALT && mode_r != LPMC_ST_HALT) begin
            halt_sub_r <= (mode_r == LPMC_ST_NORM_SUB);            // RL7
         end
      end
   end

   // cpu and clock outputs; registers are never cleared on low-power entry
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cpu_run_r     <= 1'b1;
         cpu_clk_sub_r <= 1'b0;
         main_osc_en_r <= `LPMC_OSC_ON;
         sub_osc_en_r  <= `LPMC_OSC_ON;
      end else begin
         cpu_run_r     <= !((state_nxt == LPMC_ST_SLEEP) || (state_nxt == LPMC_ST_SUBSLEEP) ||
                            (state_nxt == LPMC_ST_HALT));           // RL6 RL9 RL10
         cpu_clk_sub_r <= on_sub_nxt;                               // RL2
         main_osc_en_r <= main_osc_nxt;
         // legacy keeps the subclock alive in every mode here
         if (legacy) begin
            sub_osc_en_r <= `LPMC_OSC_ON;                           // RL10
         end else if (state_nxt != LPMC_ST_HALT) begin
            sub_osc_en_r <= sub_osc_req | on_sub_nxt;               // RL7
         end
      end
   end

   // peripheral gating; everything not named stays operable
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         adc_en_r     <= 1'b1;
         i2c_en_r     <= 1'b1;
         crc_en_r     <= 1'b1;
         timer_rst_r  <= 1'b0;
         serial_rst_r <= `LPMC_SER_NONE;
         adc_rst_r    <= 1'b0;
         rtc_run_r    <= 1'b1;
      end else begin
         adc_en_r     <= legacy || !on_sub_nxt;                     // RL4
         i2c_en_r     <= legacy || !on_sub_nxt;                     // RL4
         crc_en_r     <= legacy || !on_sub_nxt;                     // RL4
         timer_rst_r  <= legacy && on_sub_nxt;                      // RL5
         serial_rst_r <= (legacy && on_sub_nxt) ? `LPMC_SER_ALL : `LPMC_SER_NONE; // RL5
         adc_rst_r    <= legacy && on_sub_nxt;                      // RL5
         rtc_run_r    <= !(legacy && on_sub_nxt) || rtc_timebase_sel; // RL5
      end
   end

   // ram stays retained; transfers may still reach it while the cpu rests
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ram_acc_en_r <= 1'b1;
         port_hold_r  <= 1'b0;
      end else begin
         ram_acc_en_r <= (state_nxt != LPMC_ST_HALT) || dtc_busy;   // RL8
         port_hold_r  <= (state_nxt == LPMC_ST_HALT) || (state_nxt == LPMC_ST_SLEEP) ||
                         (state_nxt == LPMC_ST_SUBSLEEP);           // RL7 RL9 RL10
      end
   end

   // freezing the pins one stage late keeps the last pre-halt value
   lpmc_port_hold u_port_hold (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .hold     (port_hold_r),
      .port_drv (port_drv),
      .port_out (port_out)
   );

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_irq_subactive: assert property (legacy && lson_r && irq && ((mode_r == LPMC_ST_ACTIVE) ||
      (mode_r == LPMC_ST_SLEEP) || (mode_r == LPMC_ST_SUBSLEEP)) |=> mode_r == LPMC_ST_SUBACTIVE) // RL1
      else $error("interrupt did not enter subactive");
   a_css_switch: assert property (!legacy && mode_r == LPMC_ST_ACTIVE && ckc_wr && subclock_select_bit
      && sub_osc_ready && !halt_instr |=> cpu_clk_sub_r && cpu_run_r) // RL2
      else $error("subclock select did not switch cpu clock");
   a_main_osc_sw: assert property ((mode_r == LPMC_ST_NORM_SUB) && $past(mode_r == LPMC_ST_NORM_SUB)
      |-> main_osc_en_r == $past(main_osc_req)) // RL3
      else $error("main oscillator ignored software choice");
   a_sub_periph_off: assert property (!legacy && cpu_clk_sub_r |-> !adc_en_r && !i2c_en_r && !crc_en_r) // RL4
      else $error("peripheral enabled on subclock");
   a_legacy_resets: assert property (legacy && cpu_clk_sub_r |-> timer_rst_r && adc_rst_r &&
      (serial_rst_r == `LPMC_SER_ALL) && (rtc_run_r == $past(rtc_timebase_sel))) // RL5
      else $error("legacy sub mode reset set wrong");
   a_halt_entry: assert property (!legacy && halt_instr && mode_r != LPMC_ST_HALT |=>
      mode_r == LPMC_ST_HALT && !cpu_run_r ##1 port_hold_r) // RL6
      else $error("halt instruction not honoured");
   a_halt_osc_keep: assert property (mode_r == LPMC_ST_HALT && $past(mode_r == LPMC_ST_HALT)
      |-> $stable(main_osc_en_r) && $stable(sub_osc_en_r) && $stable(port_out)) // RL7
      else $error("halt changed oscillator or port");
   a_ram_dtc: assert property (dtc_busy |=> ram_acc_en_r) // RL8
      else $error("ram blocked during transfer");
   a_sleep_enter: assert property (legacy && mode_r == LPMC_ST_ACTIVE && sleep_instr && !irq &&
      sel_r == `LPMC_SEL_SLEEP |=> mode_r == LPMC_ST_SLEEP && !cpu_run_r && main_osc_en_r) // RL9 RL12
      else $error("sleep mode entry wrong");
   a_subsleep_osc: assert property (mode_r == LPMC_ST_SUBSLEEP |-> !main_osc_en_r && sub_osc_en_r
      && !cpu_run_r) // RL10
      else $error("subsleep oscillator state wrong");
   a_halt_wake: assert property (mode_r == LPMC_ST_HALT && irq |=> cpu_run_r) // RL11
      else $error("halt wake delayed");

   c_halt_wake: cover property (mode_r == LPMC_ST_HALT ##1 mode_r != LPMC_ST_HALT);
   c_norm_sub:  cover property (mode_r == LPMC_ST_NORM_SUB ##[1:4] mode_r == LPMC_ST_HALT);
   c_subsleep:  cover property (mode_r == LPMC_ST_SUBSLEEP ##1 mode_r == LPMC_ST_SUBACTIVE);
   c_dtc_halt:  cover property (mode_r == LPMC_ST_HALT && dtc_busy);
endmodule
`default_nettype wire

/* File: lpmc_cpu.sv */
// Purpose: cpu core model issuing mode instructions and control writes
// Assumes: strobes rise just after a clock edge and last one cycle
// Notes:   select bit data is inverted once its strobe drops, so the design must sample it with the strobe
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_defs.svh"
module lpmc_cpu (
   input  wire logic                   clk_sys,             // system clock
   output var logic                    sleep_instr,         // sleep instruction pulse
   output var logic                    halt_instr,          // halt instruction pulse
   output var logic                    mode_sel_wr,         // mode-select write pulse
   output var logic [`LPMC_SEL_W-1:0]  mode_sel_val,        // sleep target
   output var logic                    low_speed_on,        // irq wakes to subactive
   output var logic                    ckc_wr,              // clock_control_reg write pulse
   output var logic                    subclock_select_bit  // select bit write data
);
   // quiet bus from time zero
   initial begin
      {sleep_instr, halt_instr, mode_sel_wr, ckc_wr, low_speed_on} = 5'h00;
      mode_sel_val = `LPMC_SEL_SLEEP;
      subclock_select_bit = 1'b0;
   end
   // mode select stays put after the write, as software leaves it
   task automatic sel_write(input logic [`LPMC_SEL_W-1:0] v, input logic ls);
      @(posedge clk_sys);
      mode_sel_val <= v;
      low_speed_on <= ls;
      mode_sel_wr  <= 1'b1;
      @(posedge clk_sys);
      mode_sel_wr  <= 1'b0;
   endtask
   task automatic exec_sleep();
      @(posedge clk_sys);
      sleep_instr <= 1'b1;
      @(posedge clk_sys);
      sleep_instr <= 1'b0;
   endtask
   task automatic exec_halt();
      @(posedge clk_sys);
      halt_instr <= 1'b1;
      @(posedge clk_sys);
      halt_instr <= 1'b0;
   endtask
   // writing 1 asks for the subclock; the data line is inverted after the strobe
   task automatic ckc_write(input logic b);
      @(posedge clk_sys);
      subclock_select_bit <= b;
      ckc_wr              <= 1'b1;
      @(posedge clk_sys);
      ckc_wr              <= 1'b0;
      subclock_select_bit <= ~b;
   endtask
   // slow core: idle cycles between requests
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: self-checking bench for both controller personalities
// Assumes: instance 0 is legacy, instance 1 newer; cpu model shared
// Notes:   irq is per instance so one personality never disturbs the other
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_defs.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; $display("Error: %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   import lpmc_pkg::*;
   localparam int L = 0;
   localparam int N = 1;
   logic                    clk_sys = 1'b0;
   logic                    reset = 1'b1;
   logic                    irq [2];
   logic                    sub_osc_ready, main_osc_req, sub_osc_req, rtc_timebase_sel, dtc_busy;
   logic [`LPMC_PORT_W-1:0] port_drv;
   wire                     sleep_instr, halt_instr, mode_sel_wr, low_speed_on, ckc_wr, subclock_select_bit;
   wire  [`LPMC_SEL_W-1:0]  mode_sel_val;
   lpmc_state_t             mode_r [2];
   logic                    cpu_run_r [2], cpu_clk_sub_r [2], main_osc_en_r [2], sub_osc_en_r [2], adc_en_r [2];
   logic                    i2c_en_r [2], crc_en_r [2], timer_rst_r [2], adc_rst_r [2], rtc_run_r [2];
   logic                    ram_acc_en_r [2], port_hold_r [2];
   logic [`LPMC_NSER-1:0]   serial_rst_r [2];
   logic [`LPMC_PORT_W-1:0] port_out [2];
   int                      checks = 0;
   int                      failures = 0;
   always #2 clk_sys = ~clk_sys;
   lpmc_cpu i_lpmc_cpu (.clk_sys(clk_sys), .sleep_instr(sleep_instr), .halt_instr(halt_instr),
      .mode_sel_wr(mode_sel_wr), .mode_sel_val(mode_sel_val), .low_speed_on(low_speed_on), .ckc_wr(ckc_wr),
      .subclock_select_bit(subclock_select_bit));
   // g == N selects the newer personality
   for (genvar g = 0; g < 2; g++) begin : g_dut
      lpmc_ctrl #(.PERSONALITY(g == N)) i_lpmc_ctrl (.clk_sys(clk_sys), .reset(reset), .sleep_instr(sleep_instr),
         .halt_instr(halt_instr), .irq(irq[g]), .mode_sel_wr(mode_sel_wr), .mode_sel_val(mode_sel_val),
         .low_speed_on(low_speed_on), .ckc_wr(ckc_wr), .subclock_select_bit(subclock_select_bit),
         .sub_osc_ready(sub_osc_ready), .main_osc_req(main_osc_req), .sub_osc_req(sub_osc_req),
         .rtc_timebase_sel(rtc_timebase_sel), .dtc_busy(dtc_busy), .port_drv(port_drv), .mode_r(mode_r[g]),
         .cpu_run_r(cpu_run_r[g]), .cpu_clk_sub_r(cpu_clk_sub_r[g]), .main_osc_en_r(main_osc_en_r[g]),
         .sub_osc_en_r(sub_osc_en_r[g]), .adc_en_r(adc_en_r[g]), .i2c_en_r(i2c_en_r[g]), .crc_en_r(crc_en_r[g]),
         .timer_rst_r(timer_rst_r[g]), .serial_rst_r(serial_rst_r[g]), .adc_rst_r(adc_rst_r[g]),
         .rtc_run_r(rtc_run_r[g]), .ram_acc_en_r(ram_acc_en_r[g]), .port_hold_r(port_hold_r[g]),
         .port_out(port_out[g]));
   end
   task report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // common mode summary of one instance
   task see(input int g, input lpmc_state_t m, input logic run, input logic mosc, input logic hold);
      `CHK("mode", m, mode_r[g])
      `CHK("cpu_run", run, cpu_run_r[g])
      `CHK("main_osc", mosc, main_osc_en_r[g])
      `CHK("port_hold", hold, port_hold_r[g])
   endtask
   // legacy peripheral resets all follow one level
   task subrst(input logic r);
      `CHK("timer_rst", r, timer_rst_r[L])
      `CHK("serial_rst", r ? `LPMC_SER_ALL : `LPMC_SER_NONE, serial_rst_r[L])
      `CHK("adc_rst", r, adc_rst_r[L])
   endtask
   // one-cycle interrupt, judged just after the edge that takes it
   task pulse_irq(input int g);
      @(posedge clk_sys);
      irq[g] <= 1'b1;
      @(posedge clk_sys);
      irq[g] <= 1'b0;
      #1;
   endtask
   task t_reset();
      #1;
      for (int g = 0; g < 2; g++) begin
         see(g, LPMC_ST_ACTIVE, 1'b1, `LPMC_OSC_ON, 1'b0);
         `CHK("port_out", `LPMC_PORT_RST, port_out[g])
      end
      $display("test reset done");
   endtask
   task t_leg_sleep();
      i_lpmc_cpu.sel_write(`LPMC_SEL_SLEEP, 1'b0);
      i_lpmc_cpu.exec_sleep();
      #1;
      see(L, LPMC_ST_SLEEP, 1'b0, `LPMC_OSC_ON, 1'b1);
      `CHK("sub_osc", `LPMC_OSC_ON, sub_osc_en_r[L])
      subrst(1'b0);
      `CHK("newer ignores sleep", LPMC_ST_ACTIVE, mode_r[N])
      pulse_irq(L);
      see(L, LPMC_ST_ACTIVE, 1'b1, `LPMC_OSC_ON, 1'b0);
      $display("test legacy sleep done");
   endtask
   task t_leg_subsleep();
      rtc_timebase_sel <= 1'b1;
      i_lpmc_cpu.sel_write(`LPMC_SEL_SUBSLEEP, 1'b1);
      i_lpmc_cpu.exec_sleep();
      #1;
      see(L, LPMC_ST_SUBSLEEP, 1'b0, `LPMC_OSC_OFF, 1'b1);
      `CHK("sub_osc", `LPMC_OSC_ON, sub_osc_en_r[L])
      subrst(1'b1);
      `CHK("rtc_run", 1'b1, rtc_run_r[L])
      pulse_irq(L);
      see(L, LPMC_ST_SUBACTIVE, 1'b1, `LPMC_OSC_OFF, 1'b0);
      `CHK("cpu_clk_sub", 1'b1, cpu_clk_sub_r[L])
      subrst(1'b1);
      i_lpmc_cpu.sel_write(2'h3, 1'b0);
      i_lpmc_cpu.exec_sleep();
      #1;
      see(L, LPMC_ST_ACTIVE, 1'b1, `LPMC_OSC_ON, 1'b0);
      subrst(1'b0);
      $display("test legacy subsleep done");
   endtask
   task t_leg_direct();
      rtc_timebase_sel <= 1'b0;
      i_lpmc_cpu.sel_write(`LPMC_SEL_SUBACT, 1'b0);
      i_lpmc_cpu.exec_sleep();
      #1;
      see(L, LPMC_ST_SUBACTIVE, 1'b1, `LPMC_OSC_OFF, 1'b0);
      `CHK("rtc_run", 1'b0, rtc_run_r[L])
      i_lpmc_cpu.sel_write(`LPMC_SEL_SLEEP, 1'b1);
      i_lpmc_cpu.exec_sleep();
      pulse_irq(L);
      see(L, LPMC_ST_SUBACTIVE, 1'b1, `LPMC_OSC_OFF, 1'b0);
      i_lpmc_cpu.sel_write(`LPMC_SEL_SLEEP, 1'b0);
      i_lpmc_cpu.exec_sleep();
      $display("test legacy direct done");
   endtask
   task t_new_sub();
      sub_osc_ready <= 1'b0;
      i_lpmc_cpu.ckc_write(1'b1);
      #1;
      `CHK("mode", LPMC_ST_ACTIVE, mode_r[N])
      `CHK("legacy ignores ckc", LPMC_ST_ACTIVE, mode_r[L])
      sub_osc_ready <= 1'b1;
      main_osc_req <= 1'b0;
      i_lpmc_cpu.ckc_write(1'b1);
      #1;
      see(N, LPMC_ST_NORM_SUB, 1'b1, `LPMC_OSC_OFF, 1'b0);
      `CHK("cpu_clk_sub", 1'b1, cpu_clk_sub_r[N])
      `CHK("adc i2c crc en", 3'h0, {adc_en_r[N], i2c_en_r[N], crc_en_r[N]})
      `CHK("timer_rst", 1'b0, timer_rst_r[N])
      main_osc_req <= 1'b1;
      i_lpmc_cpu.idle(2);
      #1;
      `CHK("main_osc", `LPMC_OSC_ON, main_osc_en_r[N])
      // software drops the sub oscillator once back on the main clock
      sub_osc_req <= 1'b0;
      i_lpmc_cpu.ckc_write(1'b0);
      #1;
      see(N, LPMC_ST_ACTIVE, 1'b1, `LPMC_OSC_ON, 1'b0);
      `CHK("adc i2c crc en", 3'h7, {adc_en_r[N], i2c_en_r[N], crc_en_r[N]})
      `CHK("sub_osc", `LPMC_OSC_OFF, sub_osc_en_r[N])
      sub_osc_req <= 1'b1;
      $display("test newer subclock done");
   endtask
   task t_new_halt();
      port_drv <= 8'h5a;
      dtc_busy <= 1'b1;
      i_lpmc_cpu.exec_halt();
      #1;
      see(N, LPMC_ST_HALT, 1'b0, `LPMC_OSC_ON, 1'b1);
      `CHK("sub_osc", `LPMC_OSC_ON, sub_osc_en_r[N])
      `CHK("ram_acc", 1'b1, ram_acc_en_r[N])
      `CHK("legacy ignores halt", LPMC_ST_ACTIVE, mode_r[L])
      port_drv <= 8'ha5;
      i_lpmc_cpu.ckc_write(1'b1);
      #1;
      `CHK("mode", LPMC_ST_HALT, mode_r[N])
      `CHK("port_out", 8'h5a, port_out[N])
      `CHK("adc_en", 1'b1, adc_en_r[N])
      pulse_irq(N);
      see(N, LPMC_ST_ACTIVE, 1'b1, `LPMC_OSC_ON, 1'b0);
      i_lpmc_cpu.idle(2);
      #1;
      `CHK("port_out", 8'ha5, port_out[N])
      dtc_busy <= 1'b0;
      $display("test newer halt done");
   endtask
   // watchdog: the whole sequence needs well under a hundred cycles
   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      report_and_stop();
   end
   initial begin
      irq = '{1'b0, 1'b0};
      {sub_osc_ready, main_osc_req, sub_osc_req, rtc_timebase_sel, dtc_busy} = 5'h0c;
      port_drv = 8'h00;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_leg_sleep();
      t_leg_subsleep();
      t_leg_direct();
      t_new_sub();
      t_new_halt();
      report_and_stop();
   end
endmodule
`default_nettype wire
